/* File: bsr_pkg.sv */
// Package: timing, address map and field constants of the battery-backed RAM port controller
package bsr_pkg;
  // --------------------------------------------------------------------
  // Clock and timing
  // --------------------------------------------------------------------
  localparam int CLK_PERIOD_NS       = 100;
  localparam int T_ADDR_TO_DATA_NS   = 70;   // addr_to_data_delay
  localparam int T_CE_TO_DATA_NS     = 70;
  localparam int T_OE_TO_DATA_NS     = 35;
  localparam int T_CYCLE_NS          = 70;
  localparam int T_WE_PULSE_NS       = 50;
  localparam int T_CE_PULSE_NS       = 55;
  localparam int T_DATA_SETUP_NS     = 30;
  localparam int T_DATA_HOLD_NS      = 5;
  localparam int T_ADDR_SETUP_NS     = 60;
  localparam int T_STROBE_FLOAT_NS   = 25;   // strobe_to_float_delay
  // Least times round up to whole cycles, never below one
  function automatic int ns_to_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction
  localparam int RD_WAIT_CYC   = ns_to_cyc(T_ADDR_TO_DATA_NS > T_CE_TO_DATA_NS ?
                                           T_ADDR_TO_DATA_NS : T_CE_TO_DATA_NS);
  localparam int WR_PULSE_CYC  = ns_to_cyc(T_ADDR_SETUP_NS > T_CE_PULSE_NS ?
                                           T_ADDR_SETUP_NS : T_CE_PULSE_NS);
  localparam int HOLD_CYC      = ns_to_cyc(T_DATA_HOLD_NS);
  localparam int GAP_CYC       = ns_to_cyc(T_CYCLE_NS);
  localparam int CNT_W         = 4;
  // --------------------------------------------------------------------
  // Address map of the device
  // --------------------------------------------------------------------
  localparam logic [14:0] CLOCK_BASE_ADDR    = 15'h7ff8;
  localparam logic [14:0] CLOCK_CONTROL_ADDR = 15'h7ff8;
  localparam logic [14:0] CLOCK_LAST_ADDR    = 15'h7fff;
  localparam int          CTRL_WRITE_BIT     = 7;
  localparam int          CTRL_READ_BIT      = 6;
  // --------------------------------------------------------------------
  // Sequencer states
  // --------------------------------------------------------------------
  typedef enum logic [2:0] {BSR_IDLE, BSR_RD_WAIT, BSR_WR_PULSE, BSR_WR_HOLD, BSR_GAP} bsr_state_t;
endpackage

/* File: bsr_cnt.sv */
// Down counter that times each phase of a memory access
`timescale 1ns/100ps
`default_nettype none
module bsr_cnt
  import bsr_pkg::*;
#(
  parameter int W = CNT_W
)(
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst_b,
  input  wire logic         clk_en,
  // Control
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  output logic              done
);
  logic [W-1:0] cnt_ff;
  // A one-bit timer cannot hold a phase length and its reload at once
  if (W < 2)
  begin
    $error("bsr_cnt: width too small");
  end
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      cnt_ff <= '0;
    else if (clk_en)
    begin
      if (load)
        cnt_ff <= load_val;
      else if (cnt_ff != '0)
        cnt_ff <= cnt_ff - W'(1);
    end
  end
  assign done = (cnt_ff == '0);
endmodule
`default_nettype wire

/* File: bsr_host.sv */
// Host controller driving the battery-backed RAM and clock through its strobes
// What this block does
// - Write spans later fall to first rise
// - Address stable across whole write
// - Strobe returns high before next cycle
// - Write data set up and held
// - Output enable high during writes
// - Write pulse at least 50/55 ns
// - Address valid 60 ns before end
`timescale 1ns/100ps
`default_nettype none
module bsr_host
  import bsr_pkg::*;
#(
  parameter int AW = 15,
  parameter int DW = 8
)(
  // Clock and reset
  input  wire logic          clk_sys,
  input  wire logic          rst_b,
  input  wire logic          clk_en,
  // User request
  input  wire logic          req_valid,
  input  wire logic          req_write,
  input  wire logic [AW-1:0] req_addr,
  input  wire logic [DW-1:0] req_wdata,
  output logic               req_ready,
  // User answer
  output logic               rsp_valid,
  output logic [DW-1:0]      rsp_rdata,
  // Device pins
  output logic [AW-1:0]      addr_lines,
  output logic               chip_sel_b,
  output logic               out_en_b,
  output logic               write_en_b,
  input  wire logic [DW-1:0] data_lines_in,
  output logic [DW-1:0]      data_lines_out,
  output logic               data_lines_oe_b
);
  if (AW != 15 || DW != 8)
  begin
    $error("bsr_host: device is 32K x 8 only");
  end

  bsr_state_t        state_ff;
  logic              load;
  logic [CNT_W-1:0]  load_val;
  logic              done;

  // --------------------------------------------------------------------
  // Phase timer
  // --------------------------------------------------------------------
  bsr_cnt #(.W(CNT_W)) u_cnt (
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .clk_en   (clk_en),
    .load     (load),
    .load_val (load_val),
    .done     (done)
  );

  assign req_ready = (state_ff == BSR_IDLE);

  // --------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------
  always_comb
  begin
    load     = 1'b0;
    load_val = '0;
    unique case (state_ff)
      BSR_IDLE:
      begin
        load     = req_valid;
        load_val = req_write ? CNT_W'(WR_PULSE_CYC - 1) : CNT_W'(RD_WAIT_CYC - 1);
      end
      BSR_RD_WAIT:
      begin
        load     = done;
        load_val = CNT_W'(GAP_CYC - 1);
      end
      BSR_WR_PULSE:
      begin
        load     = done;
        load_val = CNT_W'(HOLD_CYC - 1);
      end
      BSR_WR_HOLD:
      begin
        load     = done;
        load_val = CNT_W'(GAP_CYC - 1);
      end
      BSR_GAP:
      begin
        load     = 1'b0;
        load_val = '0;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      state_ff <= BSR_IDLE;
    else if (clk_en)
    begin
      unique case (state_ff)
        BSR_IDLE:     if (req_valid) state_ff <= req_write ? BSR_WR_PULSE : BSR_RD_WAIT;
        BSR_RD_WAIT:  if (done) state_ff <= BSR_GAP;
        BSR_WR_PULSE: if (done) state_ff <= BSR_WR_HOLD;
        BSR_WR_HOLD:  if (done) state_ff <= BSR_GAP;
        BSR_GAP:      if (done) state_ff <= BSR_IDLE;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Pin drive: address held from request to idle, covering setup and hold
  // --------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      addr_lines     <= '0;
      data_lines_out <= '0;
    end
    else if (clk_en && state_ff == BSR_IDLE && req_valid)
    begin
      addr_lines     <= req_addr;
      data_lines_out <= req_wdata;
    end
  end

  // Select and write strobe fall together, so the device never drives in a write
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      chip_sel_b      <= 1'b1;
      out_en_b        <= 1'b1;
      write_en_b      <= 1'b1;
      data_lines_oe_b <= 1'b1;
    end
    else if (clk_en)
    begin
      chip_sel_b      <= ~(load && (state_ff == BSR_IDLE || state_ff == BSR_WR_PULSE)
                           ? (state_ff == BSR_IDLE) : (state_ff == BSR_RD_WAIT && !done) ||
                           (state_ff == BSR_WR_PULSE && !done));
      out_en_b        <= ~((state_ff == BSR_IDLE && req_valid && !req_write) ||
                           (state_ff == BSR_RD_WAIT && !done));
      write_en_b      <= ~((state_ff == BSR_IDLE && req_valid && req_write) ||
                           (state_ff == BSR_WR_PULSE && !done));
      data_lines_oe_b <= ~((state_ff == BSR_IDLE && req_valid && req_write) ||
                           state_ff == BSR_WR_PULSE ||
                           (state_ff == BSR_WR_HOLD && !done));
    end
  end

  // --------------------------------------------------------------------
  // Read capture at end of access wait, strobes still low
  // --------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
    end
    else if (clk_en)
    begin
      rsp_valid <= (state_ff == BSR_RD_WAIT) && done;
      if (state_ff == BSR_RD_WAIT && done)
        rsp_rdata <= data_lines_in;
    end
  end

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  sequence s_wr_start;
    $fell(write_en_b) && !chip_sel_b;
  endsequence
  // Pulse is one whole cycle with select and data, data still driven after
  sequence s_wr_low;
    (!write_en_b && !chip_sel_b && !data_lines_oe_b) ##1 !data_lines_oe_b;
  endsequence

  AST_NO_DRIVE_CLASH: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !data_lines_oe_b |-> out_en_b)
    else $error("host drives data while output enable low");
  AST_WE_PULSE: assert property (@(posedge clk_sys) disable iff (!rst_b || !clk_en)
    s_wr_start |-> s_wr_low)
    else $error("write strobe pulse too short");
  AST_WR_HAS_CS: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !write_en_b |-> !chip_sel_b)
    else $error("write strobe low without select");
  AST_ADDR_STABLE: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !chip_sel_b |=> $stable(addr_lines))
    else $error("address moved during access");
  AST_DATA_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_b || !clk_en)
    $rose(write_en_b) |-> !data_lines_oe_b && $stable(data_lines_out))
    else $error("write data not held past strobe rise");
  AST_RD_OE: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !out_en_b |-> write_en_b && !chip_sel_b)
    else $error("output enable outside a read");
  AST_RSP_AFTER_RD: assert property (@(posedge clk_sys) disable iff (!rst_b)
    $rose(rsp_valid) |-> !$past(out_en_b) && !$past(chip_sel_b))
    else $error("read answer without a read");
  AST_GAP: assert property (@(posedge clk_sys) disable iff (!rst_b || !clk_en)
    $rose(chip_sel_b) |-> chip_sel_b [*2])
    else $error("no gap after access");
endmodule
`default_nettype wire

/* File: bsr_dev_model.sv */
// Behavioural model of the battery-backed RAM with shadow clock bytes
`timescale 1ns/100ps
`default_nettype none
module bsr_dev_model
  import bsr_pkg::*;
(
  // Pins
  input  wire logic [14:0] addr_lines,
  input  wire logic        chip_sel_b,
  input  wire logic        out_en_b,
  input  wire logic        write_en_b,
  input  wire logic [7:0]  bus,
  output logic [7:0]       dev_q,
  output logic             dev_drv,
  // Supply fault and seconds tick
  input  wire logic        pwr_fail,
  input  wire logic        sec_tick
);
  // --------------------------------------------------------------------
  // Array, access timer, write window, shadow seconds
  // --------------------------------------------------------------------
  logic [7:0] mem [0:32767];
  logic       rd_ok = 1'b0;
  logic       wr_on = 1'b0;
  int         seq = 0;
  function automatic logic [7:0] bcd_inc(input logic [7:0] s);
    if (s == 8'h59)
      return 8'h00;
    if (s[3:0] == 4'h9)
      return {s[7:4] + 4'h1, 4'h0};
    return s + 8'h1;
  endfunction
  assign dev_drv = !pwr_fail && !chip_sel_b && !out_en_b && write_en_b;
  // Before access time shows wrong data on purpose, so early sampling is caught
  assign dev_q = rd_ok ? mem[addr_lines] : ~mem[addr_lines];
  always @(addr_lines or chip_sel_b or out_en_b)
  begin
    seq = seq + 1;
    rd_ok = 1'b0;
    fork
      automatic int s = seq;
      begin
        #(T_ADDR_TO_DATA_NS);
        if (s == seq)
          rd_ok = 1'b1;
      end
    join_none
  end
  always @(chip_sel_b or write_en_b)
  begin
    if (wr_on && (chip_sel_b || write_en_b) && !pwr_fail)
      mem[addr_lines] = bus;
    wr_on = !chip_sel_b && !write_en_b;
  end
  always @(posedge sec_tick)
    if (!mem[CLOCK_CONTROL_ADDR][CTRL_WRITE_BIT] && !mem[CLOCK_CONTROL_ADDR][CTRL_READ_BIT])
      mem[CLOCK_BASE_ADDR + 1] = bcd_inc(mem[CLOCK_BASE_ADDR + 1]);
endmodule
`default_nettype wire

/* File: test_bsr_host.sv */
// Self-checking bench of the RAM port controller
`timescale 1ns/100ps
`default_nettype none
module test_bsr_host
  import bsr_pkg::*;
;
  // --------------------------------------------------------------------
  // Stimulus, watchers and scenarios
  // --------------------------------------------------------------------
  logic        clk_sys = 0, rst_b = 0, clk_en = 1, req_valid = 0, req_write = 0;
  logic        pwr_fail = 0, sec_tick = 0, rnd_en = 0, req_ready, rsp_valid;
  logic        chip_sel_b, out_en_b, write_en_b, data_lines_oe_b, dev_drv;
  logic [14:0] req_addr = 0, addr_lines;
  logic [7:0]  req_wdata = 0, rsp_rdata, data_lines_out, dev_q, bus, bus_last_ff = 0;
  logic [7:0]  shadow [logic [14:0]];
  logic [7:0]  exp_q [$];
  int          fail_count = 0, tests_run = 0;
  realtime     t_a = 0, t_d = 0, t_w = 0, t_r = -100, t_c = -1000;
  // Released bus shows the inverse of its last level, not a stale copy
  assign bus = !data_lines_oe_b ? data_lines_out : dev_drv ? dev_q : ~bus_last_ff;
  always @(posedge clk_sys)
    bus_last_ff <= bus;
  initial
    forever #50 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
    #1 clk_en = rnd_en ? ($urandom_range(3) != 0) : 1'b1;
  bsr_host i_bsr_host (.clk_sys(clk_sys), .rst_b(rst_b), .clk_en(clk_en), .req_valid(req_valid),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .addr_lines(addr_lines), .chip_sel_b(chip_sel_b),
    .out_en_b(out_en_b), .write_en_b(write_en_b), .data_lines_in(bus), .data_lines_out(data_lines_out),
    .data_lines_oe_b(data_lines_oe_b));
  bsr_dev_model i_bsr_dev_model (.addr_lines(addr_lines), .chip_sel_b(chip_sel_b), .out_en_b(out_en_b),
    .write_en_b(write_en_b), .bus(bus), .dev_q(dev_q), .dev_drv(dev_drv), .pwr_fail(pwr_fail),
    .sec_tick(sec_tick));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic req(input logic w, input logic [14:0] a, input logic [7:0] d);
    int n;
    @(posedge clk_sys);
    #1;
    req_valid = 1;
    req_write = w;
    req_addr = a;
    req_wdata = d;
    n = 0;
    do
    begin
      @(negedge clk_sys);
      n++;
    end while (!(req_ready === 1'b1 && clk_en) && n < 200);
    if (n >= 200)
    begin
      chk(0, 1);
      give_verdict();
    end
    @(posedge clk_sys);
    #1 req_valid = 0;
  endtask
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    if (pwr_fail !== 1'b1)
      shadow[a] = d;
    req(1, a, d);
  endtask
  task automatic rd(input logic [14:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    req(0, a, 8'h00);
  endtask
  task automatic tick();
    @(posedge clk_sys);
    #1 sec_tick = 1;
    @(posedge clk_sys);
    #1 sec_tick = 0;
  endtask
  always @(posedge clk_sys)
    if (rsp_valid === 1'b1 && clk_en)
    begin
      if (exp_q.size() == 0)
        chk(1, 0);
      else
        chk(rsp_rdata, exp_q.pop_front());
    end
  always @(negedge clk_sys)
  begin
    chk(dev_drv & !data_lines_oe_b, 0);
    if (write_en_b === 1'b0)
      chk({out_en_b, chip_sel_b}, 2'b10);
  end
  always @(addr_lines)
    t_a = $realtime;
  always @(negedge write_en_b)
    t_w = $realtime;
  always @(negedge chip_sel_b)
  begin
    chk($realtime - t_c >= T_CYCLE_NS, 1);
    t_c = $realtime;
  end
  // Pins leave unknown at the first reset edge; that is no write
  always @(data_lines_out)
    if (rst_b)
    begin
      chk($realtime - t_r >= T_DATA_HOLD_NS, 1);
      t_d = $realtime;
    end
  always @(posedge write_en_b)
    if (rst_b)
    begin
      t_r = $realtime;
      chk(t_a <= t_w, 1);
      chk(t_r - t_w >= T_WE_PULSE_NS, 1);
      chk(t_r - t_a >= T_ADDR_SETUP_NS, 1);
      chk(t_r - t_d >= T_DATA_SETUP_NS, 1);
    end
  initial
  begin
    logic [14:0] a;
    void'($urandom(70189));
    repeat (8) @(posedge clk_sys);
    #1 rst_b = 1;
    rnd_en = 1;
    for (int i = 0; i < 24; i++)
    begin
      a = 15'($urandom_range(32'h7ff7));
      wr(a, 8'($urandom));
      rd(a, shadow[a]);
    end
    rnd_en = 0;
    $display("test plain memory done");
    wr(15'h0000, 8'h5a);
    for (int k = 0; k < 15; k++)
    begin
      wr(15'h1 << k, 8'(k));
      rd(15'h1 << k, 8'(k));
      rd(15'h0000, 8'h5a);
    end
    $display("test address decode done");
    wr(CLOCK_CONTROL_ADDR, 8'h80);
    for (int j = 1; j < 8; j++)
    begin
      wr(CLOCK_BASE_ADDR + 15'(j), 8'(j * 17));
      rd(CLOCK_BASE_ADDR + 15'(j), 8'(j * 17));
    end
    wr(CLOCK_BASE_ADDR + 15'h1, 8'h59);
    tick();
    rd(CLOCK_BASE_ADDR + 15'h1, 8'h59);
    wr(CLOCK_CONTROL_ADDR, 8'h00);
    tick();
    rd(CLOCK_BASE_ADDR + 15'h1, 8'h00);
    rd(CLOCK_CONTROL_ADDR, 8'h00);
    $display("test clock bytes done");
    // Let each write end at its strobe rise before the supply changes
    wr(15'h0123, 8'h3c);
    repeat (4) @(posedge clk_sys);
    #1 pwr_fail = 1;
    wr(15'h0123, 8'hc3);
    repeat (4) @(posedge clk_sys);
    #1 pwr_fail = 0;
    rd(15'h0123, 8'h3c);
    $display("test power fail done");
    wr(15'h0042, 8'h99);
    @(posedge clk_sys);
    #1 req_valid = 1;
    req_write = 0;
    @(negedge clk_sys);
    chk(req_ready, 0);
    @(posedge clk_sys);
    #1 req_valid = 0;
    rd(15'h0042, 8'h99);
    $display("test refused request done");
    repeat (10) @(posedge clk_sys);
    chk(16'(exp_q.size()), 0);
    give_verdict();
  end
endmodule
`default_nettype wire
